//--- inc/sdc_pkg.sv
// shared types and constants of the sdram command decoder
// assumes one clock; command pins arrive from logic on the same clock
package sdc_pkg;
   localparam int ROW_W = 11;
   localparam int COL_W = 8;
   localparam int DATA_W = 16;
   localparam int LANE_W = 8;
   localparam int LANES = 2;
   localparam int BANKS = 2;
   localparam int MODE_W = 11;
   localparam int MEM_AW = 1 + ROW_W + COL_W;
   localparam int AP_BIT = 10;
   localparam int MODE_LOW_W = 10;
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [COL_W-1:0] WRAP_1 = 8'h00;
   localparam logic [COL_W-1:0] WRAP_2 = 8'h01;
   localparam logic [COL_W-1:0] WRAP_4 = 8'h03;
   localparam logic [COL_W-1:0] WRAP_8 = 8'h07;
   localparam logic [COL_W-1:0] WRAP_FULL = 8'hFF;
   localparam logic [COL_W-1:0] LEFT_LAST = 8'h01;
   localparam logic [MODE_W-1:0] MODE_RST = 11'h000;
   localparam logic [LANES-1:0] OE_OFF = 2'h3;

   typedef struct packed {
      logic cs_b;
      logic row_strobe_b;
      logic col_strobe_b;
      logic write_strobe_b;
      logic bank_select_bit;
      logic [ROW_W-1:0] addr;
   } sdc_cmd_t;

   typedef struct packed {
      logic high_byte_mask;
      logic low_byte_mask;
   } sdc_mask_t;

   typedef enum logic [1:0] {
      ST_RUN, ST_PWR_DOWN, ST_SELF_REF, ST_SUSPEND
   } sdc_state_t;

   typedef enum logic [3:0] {
      OP_DESEL, OP_NOP, OP_BST, OP_READ, OP_WRITE,
      OP_ACT, OP_PRE, OP_REF, OP_MRS
   } sdc_op_t;
endpackage

//--- src/sdc_decoder.sv
// sdram command decoder with two banks, burst sequencing and byte masks
// assumes the controller drives commands on the same clock and obeys
// bank state; no memory content is reset
//
// Notes on behaviour
// - pins sampled on rising edge; deselect ignored; all strobes high is nop.
// - row low, column high: write high opens row, low closes bank(s).
// - column low, row high: write strobe picks write or read; bit 10 self-close.
// - all strobes low, banks idle, gate high loads mode register.
// - refresh strobes: gate high is timed refresh, falling gate standby refresh.
// - burst stop ends any ongoing burst, page bursts included.
// - power-down entry on falling gate with deselect or nop.
// - power-down and standby refresh leave on rising gate with deselect or nop.
// - falling gate with an active bank enters clock suspend.
// - rising gate leaves clock suspend whatever the command.
// - falling gate during a burst gives clock suspend, never power-down.
// - byte masks block storage in their own cycle on writes and float their lane on reads.
// - a masked byte is not stored during a write.
// - mask during a read disables that byte's output two cycles later.
// - high mask covers bits 15..8, low mask bits 7..0.
// - data captured on writes and driven on reads on rising edges.
// - row from bits 0..10, column from bits 0..7, mode from address bits 0..9 plus bank bit.
// - low gate freezes internal clock, outputs and burst address.
`timescale 1ns/1ps
module sdc_decoder
   import sdc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire sdc_pkg::sdc_cmd_t cmd_i,
   input wire logic clock_gate_now_i,
   input wire sdc_pkg::sdc_mask_t byte_mask_i,
   input wire logic [sdc_pkg::DATA_W-1:0] data_lines_i,
   output logic [sdc_pkg::DATA_W-1:0] data_lines_o,
   output logic [sdc_pkg::LANES-1:0] data_lines_oe_b_o,
   output logic [sdc_pkg::BANKS-1:0] bank_active_o,
   output logic [sdc_pkg::MODE_W-1:0] mode_reg_o,
   output sdc_pkg::sdc_state_t power_state_o,
   output logic timed_refresh_o,
   output logic burst_busy_o
);
   import sdc_pkg::*;

   logic clock_gate_prev;
   sdc_state_t state;
   logic [BANKS-1:0] bank_active;
   logic [ROW_W-1:0] open_row [BANKS];
   logic [MODE_W-1:0] mode_reg;
   logic bst_on;
   logic bst_wr;
   logic bst_bank;
   logic bst_ap;
   logic [COL_W-1:0] bst_col;
   logic [COL_W-1:0] bst_left;
   logic [DATA_W-1:0] mem [2**MEM_AW];
   logic [DATA_W-1:0] rd_word;
   logic rd_live;
   logic [LANES-1:0] rd_mask;

   sdc_op_t op;
   logic run;
   logic tbank;
   logic tact;
   logic all_idle;
   logic rw_go;
   logic full;
   logic cut;
   logic acc;
   logic acc_wr;
   logic acc_bank;
   logic [COL_W-1:0] acc_col;
   logic [COL_W-1:0] len_m;
   logic [COL_W-1:0] wrap_m;
   logic [COL_W-1:0] next_bst_col;
   logic last;
   logic ap_close;
   logic [MEM_AW-1:0] acc_addr;
   logic [LANES-1:0] mv;
   logic [MODE_W-1:0] mrs_val;
   logic idle_cmd;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // strobe pattern to operation
   function automatic sdc_op_t decode(input sdc_cmd_t c);
      sdc_op_t o;
      o = OP_DESEL;
      if (!c.cs_b) begin
         unique case ({c.row_strobe_b, c.col_strobe_b, c.write_strobe_b})
            3'h7: o = OP_NOP;
            3'h6: o = OP_BST;
            3'h5: o = OP_READ;
            3'h4: o = OP_WRITE;
            3'h3: o = OP_ACT;
            3'h2: o = OP_PRE;
            3'h1: o = OP_REF;
            3'h0: o = OP_MRS;
         endcase
      end
      return o;
   endfunction

   // burst length field to column wrap mask
   function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] f);
      logic [COL_W-1:0] m;
      m = WRAP_1;
      unique case (f)
         BL_1: m = WRAP_1;
         BL_2: m = WRAP_2;
         BL_4: m = WRAP_4;
         BL_8: m = WRAP_8;
         BL_FULL: m = WRAP_FULL;
         default: m = WRAP_1;
      endcase
      return m;
   endfunction

   always_comb begin
      op = decode(cmd_i);
      run = (state == ST_RUN);
      tbank = cmd_i.bank_select_bit;
      tact = bank_active[tbank];
      all_idle = (bank_active == '0);
      idle_cmd = (op == OP_NOP) || (op == OP_DESEL);
      mv = byte_mask_i;
      full = (mode_reg[2:0] == BL_FULL);
      len_m = full ? WRAP_1 : bl_mask(mode_reg[2:0]);
      wrap_m = bl_mask(mode_reg[2:0]);
      // access only to an active bank
      rw_go = run && ((op == OP_READ) || (op == OP_WRITE)) && tact;
      cut = (op == OP_BST) ||
         ((op == OP_PRE) && (cmd_i.addr[AP_BIT] || (tbank == bst_bank)));
      acc = rw_go || (run && bst_on && !cut);
      acc_wr = rw_go ? (op == OP_WRITE) : bst_wr;
      acc_bank = rw_go ? tbank : bst_bank;
      acc_col = rw_go ? cmd_i.addr[COL_W-1:0] : bst_col;
      acc_addr = {acc_bank, open_row[acc_bank], acc_col};
      next_bst_col = (acc_col & ~wrap_m) | (COL_W'(acc_col + 1'b1) & wrap_m);
      last = rw_go ? (!full && (len_m == WRAP_1)) : (!full && (bst_left == LEFT_LAST));
      ap_close = acc && last && (rw_go ? cmd_i.addr[AP_BIT] : bst_ap);
      mrs_val = {tbank, cmd_i.addr[MODE_LOW_W-1:0]};
   end

   // burst sequencing
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         bst_on <= 1'b0;
         bst_wr <= 1'b0;
         bst_bank <= 1'b0;
         bst_ap <= 1'b0;
         bst_col <= '0;
         bst_left <= '0;
      end else if (run) begin
         if (rw_go) begin
            bst_on <= full || (len_m != WRAP_1);
            bst_wr <= (op == OP_WRITE);
            bst_bank <= tbank;
            bst_ap <= cmd_i.addr[AP_BIT];
            bst_col <= next_bst_col;
            bst_left <= len_m;
         end else if (bst_on) begin
            if (cut || last) begin
               bst_on <= 1'b0;
            end else begin
               bst_col <= next_bst_col;
               bst_left <= bst_left - LEFT_LAST;
            end
         end
      end
   end

   // bank open and close
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         bank_active <= '0;
      end else if (run) begin
         for (int b = 0; b < BANKS; b++) begin
            if ((op == OP_ACT) && (tbank == b) && !bank_active[b]) begin
               bank_active[b] <= 1'b1;
            end else if ((op == OP_PRE) && (cmd_i.addr[AP_BIT] || (tbank == b))) begin
               bank_active[b] <= 1'b0;
            end else if (ap_close && (acc_bank == b)) begin
               bank_active[b] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (run && (op == OP_ACT) && !tact) begin
         open_row[tbank] <= cmd_i.addr;
      end
   end

   // mode register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         mode_reg <= MODE_RST;
      end else if (run && (op == OP_MRS) && all_idle && clock_gate_now_i) begin
         mode_reg <= mrs_val;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         timed_refresh_o <= 1'b0;
      end else begin
         timed_refresh_o <= run && (op == OP_REF) && all_idle && clock_gate_now_i;
      end
   end

   // power and suspend states
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         clock_gate_prev <= 1'b1;
      end else begin
         clock_gate_prev <= clock_gate_now_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state <= ST_RUN;
      end else begin
         unique case (state)
            ST_RUN: begin
               if (!clock_gate_now_i) begin
                  if ((op == OP_REF) && all_idle && !bst_on) begin
                     state <= ST_SELF_REF;
                  end else if (bst_on || !all_idle) begin
                     state <= ST_SUSPEND;
                  end else if (idle_cmd) begin
                     state <= ST_PWR_DOWN;
                  end else begin
                     state <= ST_SUSPEND;
                  end
               end
            end
            ST_PWR_DOWN, ST_SELF_REF: begin
               if (clock_gate_now_i && !clock_gate_prev && idle_cmd) begin
                  state <= ST_RUN;
               end
            end
            ST_SUSPEND: begin
               if (clock_gate_now_i && !clock_gate_prev) begin
                  state <= ST_RUN;
               end
            end
         endcase
      end
   end

   // write lanes, each masked only in its own cycle
   always_ff @(posedge sys_clk_i) begin
      if (acc && acc_wr) begin
         for (int g = 0; g < LANES; g++) begin
            if (!mv[g]) begin
               mem[acc_addr][g*LANE_W +: LANE_W] <= data_lines_i[g*LANE_W +: LANE_W];
            end
         end
      end
   end

   // read fetch stage, mask sampled with the access
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         rd_live <= 1'b0;
         rd_mask <= '0;
      end else if (run) begin
         rd_live <= acc && !acc_wr;
         rd_mask <= mv;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (run) begin
         rd_word <= mem[acc_addr];
      end
   end

   // output stage, frozen while suspended
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         data_lines_o <= '0;
         data_lines_oe_b_o <= OE_OFF;
      end else if (run) begin
         data_lines_o <= rd_word;
         for (int g = 0; g < LANES; g++) begin
            data_lines_oe_b_o[g] <= !(rd_live && !rd_mask[g]);
         end
      end
   end

   assign bank_active_o = bank_active;
   assign mode_reg_o = mode_reg;
   assign power_state_o = state;
   assign burst_busy_o = bst_on;

   sequence rd_masked_s;
      run && acc && !acc_wr && mv[1] ##1 run;
   endsequence

   sequence rd_open_s;
      run && acc && !acc_wr && !mv[0] ##1 run;
   endsequence

   desel_holds_a: assert property (run && (op == OP_DESEL) && !bst_on
      |=> $stable(bank_active) && $stable(mode_reg))
      else $error("deselect changed bank or mode state");
   act_opens_a: assert property (run && (op == OP_ACT) && !tact
      |=> bank_active[$past(tbank)])
      else $error("row open did not activate bank");
   pre_all_a: assert property (run && (op == OP_PRE) && cmd_i.addr[AP_BIT]
      |=> bank_active == '0)
      else $error("close of both banks left one active");
   rw_idle_a: assert property (run && !tact && !bst_on
      && ((op == OP_READ) || (op == OP_WRITE)) |=> !bst_on)
      else $error("access to idle bank started a burst");
   mrs_load_a: assert property (run && (op == OP_MRS) && all_idle
      && clock_gate_now_i |=> mode_reg == $past(mrs_val))
      else $error("mode register not loaded");
   sref_entry_a: assert property (run && (op == OP_REF) && all_idle
      && !bst_on && !clock_gate_now_i |=> state == ST_SELF_REF)
      else $error("standby refresh not entered");
   bst_stop_a: assert property (run && bst_on && (op == OP_BST) |=> !bst_on)
      else $error("burst stop did not end burst");
   suspend_in_a: assert property (run && (bst_on || !all_idle)
      && !clock_gate_now_i |=> state == ST_SUSPEND)
      else $error("clock suspend not entered");
   suspend_out_a: assert property ((state == ST_SUSPEND) && clock_gate_now_i
      && !clock_gate_prev |=> state == ST_RUN)
      else $error("clock suspend not left");
   pd_exit_a: assert property ((state == ST_PWR_DOWN) && !clock_gate_prev
      && clock_gate_now_i && idle_cmd |=> state == ST_RUN)
      else $error("power-down not left");
   rd_mask_a: assert property (rd_masked_s |=> data_lines_oe_b_o[1])
      else $error("masked read byte was driven");
   rd_drive_a: assert property (rd_open_s |=> !data_lines_oe_b_o[0])
      else $error("unmasked read byte not driven");
   frozen_a: assert property ((state == ST_SUSPEND) && !clock_gate_now_i
      |=> $stable(bst_col) && $stable(data_lines_o))
      else $error("state moved during clock suspend");
endmodule // sdc_decoder

//--- sim/sdc_ctrl_model.sv
// memory controller model: commands, clock gate, byte masks, write data
// assumes bank flags from the decoder show the bank state it accepted
`timescale 1ns/1ps
module sdc_ctrl_model
   import sdc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic [sdc_pkg::BANKS-1:0] bank_active_i,
   output sdc_pkg::sdc_cmd_t cmd_o,
   output logic clock_gate_o,
   output sdc_pkg::sdc_mask_t byte_mask_o,
   output logic [sdc_pkg::DATA_W-1:0] data_o
);
   import sdc_pkg::*;

   logic lax;
   initial begin
      lax = 1'b0;
      cmd_o = 16'hFFFF;
      clock_gate_o = 1'b1;
      byte_mask_o = 2'h0;
      data_o = 16'h0000;
   end
   // one command per edge; lax lets a scenario address a bank in the wrong state
   task automatic step(input logic [3:0] op, input logic bk, input logic [10:0] a,
      input logic g, input logic [1:0] m, input logic dv, input logic [15:0] d);
      logic [3:0] eff;
      eff = op;
      if (!lax && op == 4'h3 && bank_active_i[bk]) eff = 4'h7;
      if (!lax && op[3:1] == 3'h2 && !bank_active_i[bk]) eff = 4'h7;
      cmd_o = {eff, bk, a};
      clock_gate_o = g;
      byte_mask_o = m;
      // released bus shows the inverse of its previous value each step
      data_o = dv ? d : ~data_o;
      @(posedge sys_clk_i);
      #1;
   endtask
endmodule // sdc_ctrl_model

//--- sim/test_sdc_decoder.sv
// testbench of the sdram command decoder
// assumes the controller model in sdc_ctrl_model and the sdc_pkg package
`timescale 1ns/1ps
module test_sdc_decoder;
   import sdc_pkg::*;
   localparam logic [3:0] NOP = 4'h7;
   localparam logic [3:0] BST = 4'h6;
   localparam logic [3:0] RD = 4'h5;
   localparam logic [3:0] WR = 4'h4;
   localparam logic [3:0] ACT = 4'h3;
   localparam logic [3:0] PRE = 4'h2;
   localparam logic [3:0] REF = 4'h1;
   localparam logic [3:0] MRS = 4'h0;
   logic sys_clk_i;
   logic rst_b_i;
   sdc_cmd_t cmd;
   logic gate;
   sdc_mask_t mask;
   logic [15:0] ctl_d;
   logic [15:0] dq_in;
   logic [15:0] dq_out;
   logic [1:0] oe_b;
   logic [1:0] bank;
   logic [10:0] mode;
   sdc_state_t pstate;
   logic ref_p;
   logic busy;
   int fails;
   int checked;
   int cycles;

   // wire level per lane from both drivers
   assign dq_in = {oe_b[1] ? ctl_d[15:8] : dq_out[15:8], oe_b[0] ? ctl_d[7:0] : dq_out[7:0]};

   sdc_decoder i_sdc_decoder (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cmd_i(cmd),
      .clock_gate_now_i(gate), .byte_mask_i(mask), .data_lines_i(dq_in),
      .data_lines_o(dq_out), .data_lines_oe_b_o(oe_b), .bank_active_o(bank),
      .mode_reg_o(mode), .power_state_o(pstate), .timed_refresh_o(ref_p),
      .burst_busy_o(busy));
   sdc_ctrl_model i_sdc_ctrl_model (.sys_clk_i(sys_clk_i), .bank_active_i(bank),
      .cmd_o(cmd), .clock_gate_o(gate), .byte_mask_o(mask), .data_o(ctl_d));

   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   task automatic end_sim();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge sys_clk_i) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         fails = fails + 1;
         $display("mismatch at %0t: timeout", $time);
         end_sim();
      end
   end

   task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked = checked + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_s(input sdc_state_t got, input sdc_state_t exp, input string what);
      checked = checked + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("mismatch at %0t: %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic c(input logic [3:0] op, input logic bk, input logic [10:0] a);
      i_sdc_ctrl_model.step(op, bk, a, 1'b1, 2'h0, 1'b0, 16'h0000);
   endtask

   task automatic g(input logic [3:0] op, input logic gt);
      i_sdc_ctrl_model.step(op, 1'b0, 11'h000, gt, 2'h0, 1'b0, 16'h0000);
   endtask

   task automatic test_write_read();
      c(MRS, 1'b0, 11'h001);
      chk_v({5'h00, mode}, 16'h0001, "mode");
      c(ACT, 1'b0, 11'h123);
      chk_v({14'h0000, bank}, 16'h0001, "open");
      i_sdc_ctrl_model.step(WR, 1'b0, 11'h004, 1'b1, 2'h0, 1'b1, 16'h1111);
      chk_v({15'h0000, busy}, 16'h0001, "busy");
      i_sdc_ctrl_model.step(NOP, 1'b0, 11'h000, 1'b1, 2'h0, 1'b1, 16'h2222);
      chk_v({15'h0000, busy}, 16'h0000, "idle");
      i_sdc_ctrl_model.step(WR, 1'b0, 11'h004, 1'b1, 2'h1, 1'b1, 16'h3333);
      i_sdc_ctrl_model.step(NOP, 1'b0, 11'h000, 1'b1, 2'h2, 1'b1, 16'h4444);
      i_sdc_ctrl_model.step(RD, 1'b0, 11'h404, 1'b1, 2'h0, 1'b0, 16'h0000);
      i_sdc_ctrl_model.step(NOP, 1'b0, 11'h000, 1'b1, 2'h2, 1'b0, 16'h0000);
      chk_v(dq_out, 16'h3311, "beat0");
      chk_v({14'h0000, oe_b}, 16'h0000, "oe0");
      chk_v({14'h0000, bank}, 16'h0000, "selfclose");
      c(NOP, 1'b0, 11'h000);
      chk_v({8'h00, dq_out[7:0]}, 16'h0044, "beat1");
      chk_v({14'h0000, oe_b}, 16'h0002, "oe1");
      c(NOP, 1'b0, 11'h000);
      chk_v({14'h0000, oe_b}, 16'h0003, "oe2");
      $display("test_write_read done");
   endtask

   task automatic test_bank_cmds();
      i_sdc_ctrl_model.lax = 1'b1;
      c(4'hB, 1'b0, 11'h000);
      chk_v({14'h0000, bank}, 16'h0000, "deselect");
      c(RD, 1'b0, 11'h000);
      c(NOP, 1'b0, 11'h000);
      chk_v({14'h0000, oe_b}, 16'h0003, "idle read");
      i_sdc_ctrl_model.lax = 1'b0;
      c(REF, 1'b0, 11'h000);
      chk_v({15'h0000, ref_p}, 16'h0001, "refresh");
      c(NOP, 1'b0, 11'h000);
      chk_v({15'h0000, ref_p}, 16'h0000, "pulse");
      c(MRS, 1'b0, 11'h003);
      c(ACT, 1'b1, 11'h7FF);
      c(MRS, 1'b0, 11'h002);
      chk_v({5'h00, mode}, 16'h0003, "mode busy");
      i_sdc_ctrl_model.step(WR, 1'b1, 11'h000, 1'b1, 2'h0, 1'b1, 16'h5A5A);
      c(NOP, 1'b0, 11'h000);
      chk_v({15'h0000, busy}, 16'h0001, "bl8");
      c(BST, 1'b0, 11'h000);
      chk_v({15'h0000, busy}, 16'h0000, "stop");
      c(ACT, 1'b0, 11'h000);
      chk_v({14'h0000, bank}, 16'h0003, "both");
      c(PRE, 1'b1, 11'h000);
      chk_v({14'h0000, bank}, 16'h0001, "close one");
      c(ACT, 1'b1, 11'h000);
      c(PRE, 1'b0, 11'h400);
      chk_v({14'h0000, bank}, 16'h0000, "close all");
      $display("test_bank_cmds done");
   endtask

   task automatic test_power();
      g(NOP, 1'b0);
      chk_s(pstate, ST_PWR_DOWN, "pd entry");
      g(ACT, 1'b1);
      chk_s(pstate, ST_PWR_DOWN, "pd hold");
      g(NOP, 1'b0);
      g(NOP, 1'b1);
      chk_s(pstate, ST_RUN, "pd exit");
      g(REF, 1'b0);
      chk_s(pstate, ST_SELF_REF, "sr entry");
      g(NOP, 1'b1);
      chk_s(pstate, ST_RUN, "sr exit");
      c(ACT, 1'b0, 11'h000);
      g(4'hF, 1'b0);
      chk_s(pstate, ST_SUSPEND, "suspend");
      g(REF, 1'b1);
      chk_s(pstate, ST_RUN, "resume");
      c(PRE, 1'b0, 11'h400);
      $display("test_power done");
   endtask

   // full page burst suspended by the gate, then resumed and stopped
   task automatic test_suspend();
      c(MRS, 1'b0, 11'h007);
      c(ACT, 1'b0, 11'h055);
      i_sdc_ctrl_model.step(WR, 1'b0, 11'h010, 1'b1, 2'h0, 1'b1, 16'hC001);
      i_sdc_ctrl_model.step(NOP, 1'b0, 11'h000, 1'b1, 2'h0, 1'b1, 16'hC002);
      c(BST, 1'b0, 11'h000);
      chk_v({15'h0000, busy}, 16'h0000, "page write stop");
      c(RD, 1'b0, 11'h010);
      g(NOP, 1'b0);
      chk_s(pstate, ST_SUSPEND, "burst suspend");
      chk_v(dq_out, 16'hC001, "page beat0");
      g(NOP, 1'b0);
      chk_v(dq_out, 16'hC001, "frozen data");
      chk_v({15'h0000, busy}, 16'h0001, "frozen burst");
      g(NOP, 1'b1);
      chk_s(pstate, ST_RUN, "burst resume");
      c(BST, 1'b0, 11'h000);
      chk_v(dq_out, 16'hC002, "page beat1");
      chk_v({15'h0000, busy}, 16'h0000, "page read stop");
      c(PRE, 1'b0, 11'h400);
      $display("test_suspend done");
   endtask

   initial begin
      rst_b_i = 1'b0;
      fails = 0;
      checked = 0;
      cycles = 0;
      repeat (20) @(posedge sys_clk_i);
      #1;
      rst_b_i = 1'b1;
      test_write_read();
      test_bank_cmds();
      test_power();
      test_suspend();
      end_sim();
   end
endmodule // test_sdc_decoder
